// file: dv/agu_core_model.sv
// core-side partner: pointer file and request issue
`timescale 1ns/10ps
module agu_core_model (
    // clock
    input wire logic hclk,
    // request to the generator
    output logic req_valid,
    output logic req_mac,
    output logic [1:0] req_gen,
    output logic [2:0] req_mode,
    output logic req_byte,
    output logic [3:0] req_ptr_num,
    output logic [15:0] req_ptr_val,
    output logic [15:0] req_step,
    output logic [3:0] offset_register_field,
    output logic [15:0] offset_value,
    // pointer write-back
    input wire logic wb_en,
    input wire logic [3:0] wb_ptr_num,
    input wire logic [15:0] wb_val
);
    logic [15:0] w [16];

    // read straight from the array; a write-back lands before the very next request is sampled
    assign req_ptr_val = w[req_ptr_num];
    assign offset_value = w[offset_register_field];

    initial begin
        req_valid = 1'b0;
        req_mac = 1'b0;
        req_gen = 2'b00;
        req_mode = 3'b000;
        req_byte = 1'b0;
        req_ptr_num = 4'h0;
        req_step = 16'h0000;
        offset_register_field = 4'h0;
        foreach (w[i]) w[i] = 16'h0000;
    end

    always @(posedge hclk) begin
        if (wb_en === 1'b1) begin
            w[wb_ptr_num] <= wb_val;
        end
    end

    task automatic issue(input logic mac, input logic [1:0] gen,
        input logic [2:0] mode, input logic [3:0] pn,
        input logic [15:0] step, input logic [3:0] ofs,
        input logic bsz, input int idle);
        repeat (idle) @(posedge hclk);
        @(posedge hclk);
        req_valid <= 1'b1;
        req_mac <= mac;
        req_gen <= gen;
        req_mode <= mode;
        req_byte <= bsz;
        req_ptr_num <= pn;
        req_step <= step;
        offset_register_field <= ofs;
        @(posedge hclk);
        req_valid <= 1'b0;
        // stale step, mode and gen fields are inverted; pointer, offset, mac and size fields are held
        req_step <= ~step;
        req_mode <= ~mode;
        req_gen <= ~gen;
        #1;
    endtask
endmodule

// file: dv/agu_top_test.sv
// self-checking bench for the address generation unit
`timescale 1ns/10ps
module agu_top_test;
    localparam logic [2:0] M_IND = agu_pkg::MODE_IND;
    localparam logic [2:0] M_PI = agu_pkg::MODE_POSTINC;
    localparam logic [2:0] M_PD = agu_pkg::MODE_POSTDEC;
    localparam logic [2:0] M_RI = agu_pkg::MODE_PREINC;
    localparam logic [2:0] M_IX = agu_pkg::MODE_INDEXED;
    localparam logic [1:0] G_XR = agu_pkg::GEN_XR;
    localparam logic [1:0] G_XW = agu_pkg::GEN_XW;
    localparam logic [1:0] G_Y = agu_pkg::GEN_Y;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire hreadyout, hresp, ea_valid, wb_en, circ_active, rev_active;
    wire req_error, req_valid, req_mac, req_byte;
    wire [31:0] hrdata;
    wire [15:0] ea, wb_val, req_ptr_val, req_step, offset_value;
    wire [1:0] ea_gen, req_gen;
    wire [2:0] req_mode;
    wire [3:0] wb_ptr_num, offset_sel, req_ptr_num, ofs_field;
    int failures = 0;
    int tests_run = 0;
    logic [31:0] r;
    logic [15:0] p;
    logic [15:0] q;

    agu_top u_agu_top (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .req_valid(req_valid), .req_mac(req_mac), .req_gen(req_gen),
        .req_mode(req_mode), .req_byte(req_byte),
        .req_ptr_num(req_ptr_num), .req_ptr_val(req_ptr_val),
        .req_step(req_step), .offset_register_field(ofs_field),
        .offset_value(offset_value), .ea_valid(ea_valid), .ea(ea),
        .ea_gen(ea_gen), .wb_en(wb_en), .wb_ptr_num(wb_ptr_num),
        .wb_val(wb_val), .offset_sel(offset_sel),
        .circ_active(circ_active), .rev_active(rev_active),
        .req_error(req_error));

    agu_core_model u_agu_core_model (.hclk(hclk), .req_valid(req_valid),
        .req_mac(req_mac), .req_gen(req_gen), .req_mode(req_mode),
        .req_byte(req_byte), .req_ptr_num(req_ptr_num),
        .req_ptr_val(req_ptr_val), .req_step(req_step),
        .offset_register_field(ofs_field), .offset_value(offset_value),
        .wb_en(wb_en), .wb_ptr_num(wb_ptr_num), .wb_val(wb_val));

    always #12.5 hclk = ~hclk;

    function automatic logic [15:0] revadd(input logic [15:0] a,
        input logic [15:0] b);
        logic [15:0] s;
        logic c;
        c = 1'b0;
        // carry runs from the top bit downward
        for (int i = 15; i >= 0; i--) begin
            s[i] = a[i] ^ b[i] ^ c;
            c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
        end
        return s & 16'hFFFE;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task end_sim();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task setw(input logic [3:0] n, input logic [15:0] v);
        @(posedge hclk);
        #1;
        u_agu_core_model.w[n] = v;
    endtask

    task rq(input logic mac, input logic [1:0] g, input logic [2:0] m,
        input logic [3:0] pn, input logic [15:0] st,
        input logic [3:0] ofs = 0, input logic bsz = 0, input int idle = 0);
        u_agu_core_model.issue(mac, g, m, pn, st, ofs, bsz, idle);
    endtask

    task res(input logic err, input logic [15:0] e, input logic we,
        input logic [15:0] wv);
        chk(req_error, err);
        chk(ea_valid, !err);
        chk(wb_en, we);
        if (!err) chk(ea, e);
        if (we) chk(wb_val, wv);
    endtask

    task t_regs();
        bus(0, agu_pkg::OFS_CTRL, 0);
        chk(r, {16'h0, agu_pkg::CTRL_RST});
        chk(hresp, 0);
        bus(0, agu_pkg::OFS_REV, 0);
        chk(r, {16'h0, agu_pkg::REV_RST});
        for (int i = 1; i < 5; i++) begin
            bus(0, 8'(i * 4), 0);
            chk(r, {16'h0, agu_pkg::BOUND_RST});
            bus(1, 8'(i * 4), 16'hFFF0 - 16'(i));
            bus(0, 8'(i * 4), 0);
            chk(r, {16'h0, 16'hFFF0 - 16'(i)});
        end
        bus(1, 8'h40, 16'h1234);
        bus(0, 8'h40, 0);
        chk(r, 0);
        $display("register test done");
    endtask

    task t_move();
        setw(3, 16'h0010);
        setw(4, 16'h1200);
        setw(6, 16'h0100);
        rq(0, G_XR, M_IX, 4, 0, 3);
        res(0, 16'h1210, 0, 0);
        chk(offset_sel, 3);
        rq(0, G_XW, M_IX, 6, 0, 3, 0, 2);
        res(0, 16'h0110, 0, 0);
        chk(ea_gen, G_XW);
        bus(0, agu_pkg::OFS_STATUS, 0);
        chk(r, 16'h0110);
        $display("move test done");
    endtask

    task t_mac();
        setw(8, 16'h0400);
        setw(9, 16'h0500);
        setw(10, 16'h0600);
        setw(11, 16'h0700);
        setw(1, 16'h0002);
        p = 16'h0400;
        for (int s = 2; s <= 6; s += 2) begin
            rq(1, 0, M_PI, 8, 16'(s));
            res(0, p, 1, p + 16'(s));
            chk(ea_gen, G_XR);
            chk(wb_ptr_num, 8);
            p = p + 16'(s);
        end
        rq(1, 0, M_IND, 10, 0);
        res(0, 16'h0600, 0, 0);
        chk(ea_gen, G_Y);
        rq(1, 0, M_IX, 9, 0, 1);
        res(0, 16'h0502, 0, 0);
        chk(ea_gen, G_XR);
        rq(1, 0, M_IX, 11, 0, 1);
        res(0, 16'h0702, 0, 0);
        chk(ea_gen, G_Y);
        rq(1, 0, M_PD, 9, 4);
        res(0, 16'h0500, 1, 16'h04FC);
        rq(1, 0, M_IX, 8, 0, 1);
        res(1, 0, 0, 0);
        rq(1, 0, M_IX, 10, 0, 1);
        res(1, 0, 0, 0);
        rq(1, 0, M_PI, 8, 16'h0003);
        res(1, 0, 0, 0);
        rq(1, 0, M_RI, 8, 16'h0002);
        res(1, 0, 0, 0);
        rq(1, 0, M_IND, 5, 0);
        res(1, 0, 0, 0);
        $display("dual operand test done");
    endtask

    task t_xcirc();
        bus(1, agu_pkg::OFS_XSTART, 16'h1000);
        bus(1, agu_pkg::OFS_XEND, 16'h100F);
        bus(1, agu_pkg::OFS_CTRL, 16'h0FF2);
        setw(2, 16'h100E);
        rq(0, G_XR, M_PI, 2, 4);
        res(0, 16'h100E, 1, 16'h1012);
        bus(1, agu_pkg::OFS_CTRL, 16'h8FF2);
        setw(2, 16'h100E);
        setw(3, 16'h0006);
        setw(1, 16'h100E);
        rq(0, G_XR, M_PI, 2, 4);
        res(0, 16'h100E, 1, 16'h1002);
        chk(circ_active, 1);
        rq(0, G_XW, M_PD, 2, 4);
        res(0, 16'h1002, 1, 16'h100E);
        rq(0, G_XR, M_IX, 2, 0, 3);
        res(0, 16'h1004, 0, 0);
        setw(2, 16'h1013);
        rq(0, G_XR, M_IND, 2, 0);
        res(0, 16'h1003, 0, 0);
        rq(0, G_XR, M_PI, 1, 4);
        res(0, 16'h100E, 1, 16'h1012);
        chk(circ_active, 0);
        $display("x circular test done");
    endtask

    task t_ycirc();
        bus(1, agu_pkg::OFS_YSTART, 16'h2000);
        bus(1, agu_pkg::OFS_YEND, 16'h201F);
        bus(1, agu_pkg::OFS_CTRL, 16'h4F5F);
        setw(5, 16'h201E);
        rq(0, G_Y, M_RI, 5, 3);
        res(0, 16'h2000, 1, 16'h2000);
        rq(0, G_Y, M_PD, 5, 2);
        res(0, 16'h2000, 1, 16'h201E);
        bus(1, agu_pkg::OFS_CTRL, 16'h0F5F);
        rq(0, G_Y, M_RI, 5, 3);
        res(0, 16'h2021, 1, 16'h2021);
        $display("y circular test done");
    endtask

    task t_rev();
        bus(1, agu_pkg::OFS_XSTART, 16'h0800);
        bus(1, agu_pkg::OFS_XEND, 16'h080F);
        bus(1, agu_pkg::OFS_CTRL, 16'h82F2);
        bus(1, agu_pkg::OFS_REV, 16'h8008);
        setw(2, 16'h080E);
        p = revadd(16'h080E, 16'h0010);
        q = revadd(p, 16'h0010);
        // one idle cycle after the pivot write
        rq(0, G_XW, M_PI, 2, 2, 0, 0, 1);
        res(0, 16'h080E, 1, p);
        chk(rev_active, 1);
        chk(circ_active, 0);
        rq(0, G_XW, M_RI, 2, 2);
        res(0, q, 1, q);
        setw(2, 16'h0800);
        rq(0, G_XW, M_PI, 2, 2, 0, 1);
        res(0, 16'h0800, 1, 16'h0802);
        rq(0, G_XW, M_PD, 2, 2);
        res(0, 16'h0802, 1, 16'h0800);
        setw(2, 16'h080E);
        rq(0, G_XR, M_PI, 2, 4);
        res(0, 16'h080E, 1, 16'h0802);
        chk(rev_active, 0);
        bus(1, agu_pkg::OFS_REV, 16'h0008);
        setw(2, 16'h080E);
        rq(0, G_XW, M_PI, 2, 2);
        res(0, 16'h080E, 1, 16'h0800);
        $display("reversal test done");
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_move();
        t_mac();
        t_xcirc();
        t_ycirc();
        t_rev();
        end_sim();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #100000;
        failures++;
        end_sim();
    end
endmodule

// file: hdl/agu_pkg.sv
// constants, offsets and enumerations for the address generation unit
package agu_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_XSTART = 8'h04;
    localparam logic [7:0] OFS_XEND = 8'h08;
    localparam logic [7:0] OFS_YSTART = 8'h0C;
    localparam logic [7:0] OFS_YEND = 8'h10;
    localparam logic [7:0] OFS_REV = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // fields of modulo_bitrev_control
    localparam int XSEL_LSB = 0;
    localparam int YSEL_LSB = 4;
    localparam int RSEL_LSB = 8;
    localparam int YEN_BIT = 14;
    localparam int XEN_BIT = 15;
    // fields of reversal_modifier_control
    localparam int REN_BIT = 15;
    localparam int PIVOT_W = 15;

    // pointer number that switches a feature off
    localparam logic [3:0] PTR_NONE = 4'hF;

    // values after reset
    localparam logic [15:0] CTRL_RST = 16'h0FFF;
    localparam logic [15:0] BOUND_RST = 16'h0000;
    localparam logic [15:0] REV_RST = 16'h0000;

    // legal post-modify steps for the dual-operand class
    localparam logic [15:0] MAC_STEP_A = 16'h0002;
    localparam logic [15:0] MAC_STEP_B = 16'h0004;
    localparam logic [15:0] MAC_STEP_C = 16'h0006;

    // prefetch pointer numbers
    localparam logic [1:0] MAC_PTR_HI = 2'b10;

    typedef enum logic [1:0] {
        GEN_XR = 2'b00,
        GEN_XW = 2'b01,
        GEN_Y = 2'b10,
        GEN_BAD = 2'b11
    } agu_gen_t;

    typedef enum logic [2:0] {
        MODE_IND = 3'b000,
        MODE_POSTINC = 3'b001,
        MODE_POSTDEC = 3'b010,
        MODE_PREINC = 3'b011,
        MODE_PREDEC = 3'b100,
        MODE_INDEXED = 3'b101,
        MODE_LITOFS = 3'b110,
        MODE_RSVD = 3'b111
    } agu_mode_t;

endpackage

// file: hdl/agu_top.sv
// effective address generator with circular and bit-reversed modes
`timescale 1ns/10ps
module agu_top #(
    parameter int AW = 16
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // address request from the core
    input wire logic req_valid,
    input wire logic req_mac,
    input wire logic [1:0] req_gen,
    input wire logic [2:0] req_mode,
    input wire logic req_byte,
    input wire logic [3:0] req_ptr_num,
    input wire logic [15:0] req_ptr_val,
    input wire logic [15:0] req_step,
    input wire logic [3:0] offset_register_field,
    input wire logic [15:0] offset_value,
    // address result to memory and register file
    output logic ea_valid,
    output logic [15:0] ea,
    output logic [1:0] ea_gen,
    output logic wb_en,
    output logic [3:0] wb_ptr_num,
    output logic [15:0] wb_val,
    output logic [3:0] offset_sel,
    output logic circ_active,
    output logic rev_active,
    output logic req_error
);

    // arithmetic below is fixed at 16 bits
    if (AW != 16) begin : g_aw_check
        $error("agu_top: only a 16-bit address width is supported");
    end

    // register file
    logic [15:0] ctrl_r;
    logic [15:0] xstart_r;
    logic [15:0] xend_r;
    logic [15:0] ystart_r;
    logic [15:0] yend_r;
    logic [15:0] rev_r;
    // bus data phase bookkeeping
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic hready_r;
    logic [31:0] hrdata_r;
    logic hresp_r;
    // result pipeline
    logic ea_valid_r;
    logic [15:0] ea_r;
    logic [1:0] ea_gen_r;
    logic wb_en_r;
    logic [3:0] wb_ptr_r;
    logic [15:0] wb_val_r;
    logic [3:0] offset_sel_r;
    logic circ_r;
    logic rev_act_r;
    logic err_r;
    // combinational results
    logic [1:0] gen_nxt;
    logic err_nxt;
    logic circ_nxt;
    logic rev_nxt;
    logic wb_nxt;
    logic [15:0] ea_nxt;
    logic [15:0] wbv_nxt;
    logic [15:0] stepped;
    logic [15:0] raw_ea;
    logic [15:0] raw_ptr;
    logic xc_on;
    logic yc_on;
    logic addr_ph;
    logic [15:0] rd_val;

    // reverse the bit order of a word
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // add with the carry travelling from the top bit down
    function automatic logic [15:0] rev_add(input logic [15:0] a,
                                            input logic [15:0] b);
        logic [15:0] s;
        s = rev16(a) + rev16(b);
        return rev16(s);
    endfunction

    // fold an address that passed a bound back into the buffer
    function automatic logic [15:0] wrap(input logic [15:0] a,
                                         input logic [15:0] s,
                                         input logic [15:0] e);
        logic [16:0] len;
        logic [16:0] t;
        len = {1'b0, e} - {1'b0, s} + 17'h00001;
        t = {1'b0, a};
        // upper bound checked before the lower, so either direction works
        if (a > e) begin
            t = {1'b0, a} - len;
        end else if (a < s) begin
            t = {1'b0, a} + len;
        end
        return t[15:0];
    endfunction

    // register read value, before forwarding a write still in flight
    function automatic logic [15:0] reg_read(input logic [7:0] a);
        logic [15:0] v;
        v = '0;
        case (a)
            agu_pkg::OFS_CTRL: v = ctrl_r;
            agu_pkg::OFS_XSTART: v = xstart_r;
            agu_pkg::OFS_XEND: v = xend_r;
            agu_pkg::OFS_YSTART: v = ystart_r;
            agu_pkg::OFS_YEND: v = yend_r;
            agu_pkg::OFS_REV: v = rev_r;
            agu_pkg::OFS_STATUS: v = ea_r;
            default: v = '0;
        endcase
        return v;
    endfunction

    assign addr_ph = hsel && hready && htrans[1];

    always_comb begin
        rd_val = reg_read(haddr[7:0]);
        if (wr_pend_r && wr_addr_r == haddr[7:0] &&
            wr_addr_r != agu_pkg::OFS_STATUS) begin
            rd_val = hwdata[15:0];
        end
    end

    // bus address phase capture; slave never inserts wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hready_r <= 1'b1;
            hrdata_r <= 32'h00000000;
            hresp_r <= 1'b0;
        end else if (ce) begin
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
            wr_pend_r <= addr_ph && hwrite && haddr[31:8] == 24'h000000;
            wr_addr_r <= haddr[7:0];
            if (addr_ph && !hwrite) begin
                // only the low 256 bytes decode; anything above reads zero
                hrdata_r <= (haddr[31:8] == 24'h000000) ?
                    {16'h0000, rd_val} : 32'h00000000;
            end
        end
    end

    // register writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= agu_pkg::CTRL_RST;
            xstart_r <= agu_pkg::BOUND_RST;
            xend_r <= agu_pkg::BOUND_RST;
            ystart_r <= agu_pkg::BOUND_RST;
            yend_r <= agu_pkg::BOUND_RST;
            rev_r <= agu_pkg::REV_RST;
        end else if (ce && wr_pend_r) begin
            case (wr_addr_r)
                agu_pkg::OFS_CTRL: ctrl_r <= hwdata[15:0];
                agu_pkg::OFS_XSTART: xstart_r <= hwdata[15:0];
                agu_pkg::OFS_XEND: xend_r <= hwdata[15:0];
                agu_pkg::OFS_YSTART: ystart_r <= hwdata[15:0];
                agu_pkg::OFS_YEND: yend_r <= hwdata[15:0];
                agu_pkg::OFS_REV: rev_r <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // address computation for one request
    always_comb begin
        gen_nxt = req_gen;
        err_nxt = 1'b0;
        if (req_mac) begin
            gen_nxt = req_ptr_num[1] ? agu_pkg::GEN_Y : agu_pkg::GEN_XR;
            if (req_ptr_num[3:2] != agu_pkg::MAC_PTR_HI) begin
                err_nxt = 1'b1;
            end
            if (req_mode == agu_pkg::MODE_INDEXED && !req_ptr_num[0]) begin
                err_nxt = 1'b1;
            end
            case (req_mode)
                agu_pkg::MODE_IND, agu_pkg::MODE_INDEXED: ;
                agu_pkg::MODE_POSTINC, agu_pkg::MODE_POSTDEC: begin
                    if (req_step != agu_pkg::MAC_STEP_A &&
                        req_step != agu_pkg::MAC_STEP_B &&
                        req_step != agu_pkg::MAC_STEP_C) begin
                        err_nxt = 1'b1;
                    end
                end
                default: err_nxt = 1'b1;
            endcase
        end
        if (gen_nxt == agu_pkg::GEN_BAD ||
            req_mode == agu_pkg::MODE_RSVD) begin
            err_nxt = 1'b1;
        end
        // one buffer per space, any pointer but PTR_NONE may be chosen
        xc_on = ctrl_r[agu_pkg::XEN_BIT] &&
            ctrl_r[agu_pkg::XSEL_LSB +: 4] != agu_pkg::PTR_NONE &&
            ctrl_r[agu_pkg::XSEL_LSB +: 4] == req_ptr_num;
        yc_on = ctrl_r[agu_pkg::YEN_BIT] &&
            ctrl_r[agu_pkg::YSEL_LSB +: 4] != agu_pkg::PTR_NONE &&
            ctrl_r[agu_pkg::YSEL_LSB +: 4] == req_ptr_num;
        rev_nxt = rev_r[agu_pkg::REN_BIT] &&
            ctrl_r[agu_pkg::RSEL_LSB +: 4] != agu_pkg::PTR_NONE &&
            ctrl_r[agu_pkg::RSEL_LSB +: 4] == req_ptr_num &&
            gen_nxt == agu_pkg::GEN_XW && !req_byte &&
            (req_mode == agu_pkg::MODE_PREINC ||
             req_mode == agu_pkg::MODE_POSTINC);
        if (gen_nxt == agu_pkg::GEN_Y) begin
            circ_nxt = yc_on;
        end else if (gen_nxt == agu_pkg::GEN_XW) begin
            circ_nxt = xc_on && !rev_nxt;
        end else begin
            circ_nxt = xc_on && gen_nxt == agu_pkg::GEN_XR;
        end
        if (rev_nxt) begin
            // step ignored, pivot scaled to bytes
            stepped = rev_add(req_ptr_val,
                {rev_r[agu_pkg::PIVOT_W - 1:0], 1'b0}) & 16'hFFFE;
        end else if (req_mode == agu_pkg::MODE_POSTDEC ||
                     req_mode == agu_pkg::MODE_PREDEC) begin
            stepped = req_ptr_val - req_step;
        end else begin
            stepped = req_ptr_val + req_step;
        end
        raw_ea = req_ptr_val;
        raw_ptr = req_ptr_val;
        wb_nxt = 1'b0;
        case (req_mode)
            agu_pkg::MODE_POSTINC, agu_pkg::MODE_POSTDEC: begin
                raw_ptr = stepped;
                wb_nxt = 1'b1;
            end
            agu_pkg::MODE_PREINC, agu_pkg::MODE_PREDEC: begin
                raw_ea = stepped;
                raw_ptr = stepped;
                wb_nxt = 1'b1;
            end
            agu_pkg::MODE_INDEXED, agu_pkg::MODE_LITOFS: begin
                raw_ea = req_ptr_val + offset_value;
            end
            default: ;
        endcase
        if (rev_nxt) begin
            raw_ea = raw_ea & 16'hFFFE;
        end
        ea_nxt = raw_ea;
        wbv_nxt = raw_ptr;
        if (circ_nxt && gen_nxt == agu_pkg::GEN_Y) begin
            ea_nxt = wrap(raw_ea, ystart_r, yend_r) & 16'hFFFE;
            wbv_nxt = wrap(raw_ptr, ystart_r, yend_r) & 16'hFFFE;
        end else if (circ_nxt) begin
            ea_nxt = wrap(raw_ea, xstart_r, xend_r);
            wbv_nxt = wrap(raw_ptr, xstart_r, xend_r);
        end
        if (err_nxt) begin
            wb_nxt = 1'b0;
        end
    end

    // result pipeline, one cycle after the request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ea_valid_r <= 1'b0;
            ea_r <= 16'h0000;
            ea_gen_r <= 2'h0;
            wb_en_r <= 1'b0;
            wb_ptr_r <= 4'h0;
            wb_val_r <= 16'h0000;
            offset_sel_r <= 4'h0;
            circ_r <= 1'b0;
            rev_act_r <= 1'b0;
            err_r <= 1'b0;
        end else if (ce) begin
            ea_valid_r <= req_valid && !err_nxt;
            wb_en_r <= req_valid && wb_nxt;
            err_r <= req_valid && err_nxt;
            if (req_valid) begin
                ea_r <= ea_nxt;
                ea_gen_r <= gen_nxt;
                wb_ptr_r <= req_ptr_num;
                wb_val_r <= wbv_nxt;
                offset_sel_r <= offset_register_field;
                circ_r <= circ_nxt && !err_nxt;
                rev_act_r <= rev_nxt && !err_nxt;
            end
        end
    end

    assign hreadyout = hready_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
    assign ea_valid = ea_valid_r;
    assign ea = ea_r;
    assign ea_gen = ea_gen_r;
    assign wb_en = wb_en_r;
    assign wb_ptr_num = wb_ptr_r;
    assign wb_val = wb_val_r;
    assign offset_sel = offset_sel_r;
    assign circ_active = circ_r;
    assign rev_active = rev_act_r;
    assign req_error = err_r;

    mac_xmap_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && req_valid && req_mac && req_ptr_num[3:1] == 3'b100
        |=> ea_gen_r == agu_pkg::GEN_XR)
        else $error("x prefetch pointer not sent to x read");

    mac_ymap_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && req_valid && req_mac && req_ptr_num[3:1] == 3'b101
        |=> ea_gen_r == agu_pkg::GEN_Y)
        else $error("y prefetch pointer not sent to y");

    mac_index_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && req_valid && req_mac &&
        req_mode == agu_pkg::MODE_INDEXED && !req_ptr_num[0]
        |=> err_r && !ea_valid_r && !wb_en_r)
        else $error("dual-operand indexing accepted on wrong pointer");

    mac_mode_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && req_valid && req_mac &&
        (req_mode == agu_pkg::MODE_PREINC ||
         req_mode == agu_pkg::MODE_PREDEC)
        |=> err_r)
        else $error("dual-operand pre-modify not refused");

    x_circ_off_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && req_valid && req_gen != agu_pkg::GEN_Y && !req_mac &&
        !ctrl_r[agu_pkg::XEN_BIT] |=> !circ_r)
        else $error("x circular active while disabled");

    y_circ_lsb_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ea_valid_r && circ_r && ea_gen_r == agu_pkg::GEN_Y
        |-> !ea_r[0] && !wb_val_r[0])
        else $error("y circular address not word aligned");

    index_no_wb_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && req_valid && req_mode == agu_pkg::MODE_INDEXED
        |=> !wb_en_r)
        else $error("indexed access wrote the pointer back");

    rev_gen_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rev_act_r |-> ea_gen_r == agu_pkg::GEN_XW && !ea_r[0])
        else $error("reversal outside x write or odd address");

    rev_byte_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && req_valid && req_byte |=> !rev_act_r)
        else $error("reversal applied to byte write");

    rev_prio_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rev_act_r |-> !circ_r)
        else $error("circular and reversal both on x write");

    circ_bound_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && req_valid && !req_mac && req_gen == agu_pkg::GEN_XR &&
        req_mode == agu_pkg::MODE_IND && xc_on &&
        req_ptr_val > xend_r && xend_r >= xstart_r &&
        req_ptr_val - xend_r <= xend_r - xstart_r
        |=> ea_r <= $past(xend_r) && ea_r >= $past(xstart_r))
        else $error("overshoot past x end not wrapped into buffer");

endmodule
